// ---- pixel_capture_defines.vh ----
// constants for the pixel input capture front end
`ifndef PIXEL_CAPTURE_DEFINES_VH
`define PIXEL_CAPTURE_DEFINES_VH
`define PIX_WIDTH 24
`define CTL_WIDTH 3
`define SYNC_WIDTH 2
`define SYNC_STAGES 2
`define BUNDLE_WIDTH 54
`define EDGE_FALLING 1'b0
`define EDGE_RISING 1'b1
`define PIXELS_ONE 1'b0
`define PIXELS_TWO 1'b1
`define ST_OFF 2'h0
`define ST_WAIT 2'h1
`define ST_RUN 2'h2
`endif

// ---- sync_stage.v ----
// two flip-flop synchroniser for a vector of pin levels
`default_nettype none
module sync_stage #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // data
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // sync_stage
`default_nettype wire

// ---- pixel_input_capture_config.v ----
// pixel input capture front end with strap configuration
// Functional notes
// R1: edge strap low: capture all inputs on falling pixel clock edge.
// R2: edge strap high: capture all inputs on rising pixel clock edge.
// R3: pixel strap low: one 24-bit pixel per clock from even bus.
// R4: pixel strap high: two pixels per clock, even first, odd second.
// R5: power_down_n low means power down, high means normal operation.
// R6: powered down: inputs ignored, all outputs high impedance; the code drives every output low, out_enable_reg included.
// R7: powered down: no capture or transmission activity at all.
// R8: controller holds qualifier high in active video, low in blanking.
// R9: one-pixel mode ignores the odd bus completely.
// R10: after power-up, resume with current straps, no other setup.
`include "pixel_capture_defines.vh"
`default_nettype none
module pixel_input_capture_config #(
  parameter PIX_W = `PIX_WIDTH,
  parameter CTL_W = `CTL_WIDTH
) (
  // system clock and reset
  input wire clk,
  input wire rst_n,
  // straps and power control
  input wire edge_select,
  input wire pixels_per_clock_select,
  input wire power_down_n,
  // pixel source
  input wire input_pixel_clock,
  input wire [PIX_W-1:0] even_pixel_in,
  input wire [PIX_W-1:0] odd_pixel_in,
  input wire active_video_qualifier,
  input wire hsync_in,
  input wire vsync_in,
  input wire [CTL_W-1:0] general_control_in,
  // captured output
  output reg cap_valid_reg,
  output reg [PIX_W-1:0] first_pixel_reg,
  output reg [PIX_W-1:0] second_pixel_reg,
  output reg second_valid_reg,
  output reg active_video_reg,
  output reg hsync_reg,
  output reg vsync_reg,
  output reg [CTL_W-1:0] control_reg,
  output reg out_enable_reg,
  output reg powered_reg
);
  localparam BW = 2 * PIX_W + CTL_W + 3;
  wire [BW-1:0] bundle_in;
  wire [BW-1:0] bundle_s;
  wire [3:0] ctrl_s;
  wire gate_n;
  wire edge_strap_s;
  wire pix_strap_s;
  wire pclk_s;
  wire [PIX_W-1:0] even_d;
  wire [PIX_W-1:0] odd_d;
  wire av_d;
  wire hs_d;
  wire vs_d;
  wire [CTL_W-1:0] ctl_d;
  reg [BW-1:0] bundle_d_reg;
  reg [BW-1:0] bundle_d_next;
  reg clk_d_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg edge_reg;
  reg edge_next;
  reg pix_reg;
  reg pix_next;
  wire run;
  wire take;
  wire rise;
  wire fall;
  // raw pins go through the synchroniser untouched
  assign bundle_in = {odd_pixel_in, even_pixel_in,
    active_video_qualifier, hsync_in, vsync_in,
    general_control_in};
  sync_stage #(.WIDTH(BW)) u_data_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(bundle_in),
    .q(bundle_s)
  );
  sync_stage #(.WIDTH(4)) u_ctrl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({input_pixel_clock, pixels_per_clock_select,
      edge_select, power_down_n}),
    .q(ctrl_s)
  );
  // synchronised control levels
  assign gate_n = ctrl_s[0]; // R5
  assign edge_strap_s = ctrl_s[1];
  assign pix_strap_s = ctrl_s[2];
  // clock input buffer off while powered down
  assign pclk_s = ctrl_s[3] & gate_n; // R6
  // fields of the bundle seen one cycle before the edge
  assign even_d = bundle_d_reg[BW-PIX_W-1:CTL_W+3];
  assign odd_d = bundle_d_reg[BW-1:BW-PIX_W];
  assign av_d = bundle_d_reg[CTL_W+2];
  assign hs_d = bundle_d_reg[CTL_W+1];
  assign vs_d = bundle_d_reg[CTL_W];
  assign ctl_d = bundle_d_reg[CTL_W-1:0];
  assign rise = pclk_s & ~clk_d_reg;
  assign fall = ~pclk_s & clk_d_reg;
  assign run = (state_reg == `ST_RUN) && gate_n; // R7
  // pixel clock edge chosen by strap
  assign take = run &&
    ((edge_reg == `EDGE_RISING) ? rise : fall); // R1 R2
  // data input buffers off while powered down
  always @*
  begin
    bundle_d_next = bundle_s;
    if (!gate_n)
      bundle_d_next = {BW{1'b0}}; // R6
  end
  // straps taken once per power-up
  always @*
  begin
    edge_next = edge_reg;
    pix_next = pix_reg;
    if (state_reg == `ST_WAIT)
    begin
      edge_next = edge_strap_s; // R10
      pix_next = pix_strap_s; // R10
    end
  end
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `ST_OFF:
        if (gate_n)
          state_next = `ST_WAIT; // R10
      `ST_WAIT:
        state_next = gate_n ? `ST_RUN : `ST_OFF;
      `ST_RUN:
        if (!gate_n)
          state_next = `ST_OFF; // R7
      default:
        state_next = `ST_OFF;
    endcase
  end
  // control state and edge history
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= `ST_OFF;
      clk_d_reg <= 1'b0;
      bundle_d_reg <= {BW{1'b0}};
      edge_reg <= `EDGE_FALLING;
      pix_reg <= `PIXELS_ONE;
    end
    else
    begin
      state_reg <= state_next;
      clk_d_reg <= pclk_s;
      bundle_d_reg <= bundle_d_next;
      edge_reg <= edge_next;
      pix_reg <= pix_next;
    end
  end
  // status outputs
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_valid_reg <= 1'b0;
      out_enable_reg <= 1'b0;
      powered_reg <= 1'b0;
    end
    else
    begin
      cap_valid_reg <= take; // R7
      out_enable_reg <= run; // R6
      powered_reg <= gate_n; // R5
    end
  end
  // captured pixels
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_pixel_reg <= {PIX_W{1'b0}};
      second_pixel_reg <= {PIX_W{1'b0}};
      second_valid_reg <= 1'b0;
    end
    else if (!gate_n)
    begin
      first_pixel_reg <= {PIX_W{1'b0}}; // R7
      second_pixel_reg <= {PIX_W{1'b0}};
      second_valid_reg <= 1'b0;
    end
    else if (take)
    begin
      first_pixel_reg <= even_d; // R3
      if (pix_reg == `PIXELS_TWO)
      begin
        second_pixel_reg <= odd_d; // R4
        second_valid_reg <= 1'b1; // R4
      end
      else
      begin
        second_pixel_reg <= {PIX_W{1'b0}}; // R9
        second_valid_reg <= 1'b0; // R9
      end
    end
  end
  // captured qualifier, syncs and control
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_video_reg <= 1'b0;
      hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      control_reg <= {CTL_W{1'b0}};
    end
    else if (!gate_n)
    begin
      active_video_reg <= 1'b0; // R7
      hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      control_reg <= {CTL_W{1'b0}};
    end
    else if (take)
    begin
      active_video_reg <= av_d; // R8
      hsync_reg <= hs_d;
      vsync_reg <= vs_d;
      control_reg <= ctl_d;
    end
  end
endmodule // pixel_input_capture_config
`default_nettype wire

// ---- pixel_capture_asserts.sv ----
// checker for the pixel input capture front end
`default_nettype none
module pixel_capture_asserts (
  // clock, reset, pins and captured pixels
  input wire logic clk, rst_n, edge_select, pixels_per_clock_select,
  input wire logic power_down_n, input_pixel_clock,
  input wire logic [23:0] even_pixel_in, first_pixel_reg, second_pixel_reg,
  // captured outputs
  input wire logic cap_valid_reg, second_valid_reg, out_enable_reg,
  input wire logic powered_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pd_held;
    !power_down_n [*6];
  endsequence
  sequence pix_edge;
    $past(input_pixel_clock, 3) == edge_select &&
      $past(input_pixel_clock, 4) != edge_select;
  endsequence
  a_pd_no_capture: assert property (pd_held |-> !cap_valid_reg)
    else $error("capture while powered down");
  a_pd_tristate: assert property (pd_held |-> !out_enable_reg)
    else $error("outputs driven while powered down");
  a_pd_level: assert property (pd_held |-> !powered_reg)
    else $error("power down level not honoured");
  a_pd_cleared: assert property (pd_held |-> first_pixel_reg == 0)
    else $error("pixel output not cleared");
  a_edge_sel: assert property (cap_valid_reg |-> pix_edge)
    else $error("capture on wrong clock edge");
  a_mode_sel: assert property (cap_valid_reg |->
    second_valid_reg == pixels_per_clock_select)
    else $error("pixel mode mismatch");
  a_first_even: assert property (cap_valid_reg |->
    first_pixel_reg == $past(even_pixel_in, 4))
    else $error("first pixel not from even bus");
  a_odd_ignored: assert property (cap_valid_reg && !second_valid_reg |->
    second_pixel_reg == 0)
    else $error("odd bus used in one pixel mode");
  a_run_drive: assert property (cap_valid_reg |->
    out_enable_reg && powered_reg)
    else $error("capture without outputs driven");
endmodule // pixel_capture_asserts
bind pixel_input_capture_config pixel_capture_asserts u_chk (.*);
`default_nettype wire

// ---- pixel_source_model.sv ----
// controller model: pixel clock and pixel stream
`default_nettype none
module pixel_source_model (
  input wire logic clk, go, edge_sel,
  output logic pclk, took,
  output logic [53:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'h04750339;
  int n = 0, line = 0;
  initial {pclk, took, bus} = '0;
  always @(negedge clk)
  begin
    took <= 1'b0;
    n <= go ? (n + 1) % 4 : 0;
    if (go && n == 3)
    begin
      pclk <= ~pclk;
      if (~pclk == edge_sel)
        took <= 1'b1;
      else
      begin
        line <= line + 1;
        bus <= {48'({$random(seed), $random(seed)}), line % 16 < 12,
          5'($random(seed))};
      end
    end
  end
endmodule // pixel_source_model
`default_nettype wire

// ---- pixel_input_capture_config_tb.sv ----
// self-checking bench for the pixel input capture front end
`default_nettype none
module pixel_input_capture_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    n_mismatch++; $display("[ERR] %0t mismatch", $time); end end
  logic clk = 0, rst_n = 0, es = 0, ps = 0, pdn = 0, go = 0, pclk, took;
  logic cv, sv, av, hs, vs, oe, pw;
  logic [23:0] f, s;
  logic [2:0] ct;
  logic [53:0] bus;
  logic [54:0] q[$];
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  pixel_source_model src (.clk(clk), .go(go), .edge_sel(es), .pclk(pclk),
    .took(took), .bus(bus));
  pixel_input_capture_config DUT (.clk(clk), .rst_n(rst_n),
    .edge_select(es), .pixels_per_clock_select(ps), .power_down_n(pdn),
    .input_pixel_clock(pclk), .even_pixel_in(bus[53:30]),
    .odd_pixel_in(bus[29:6]), .active_video_qualifier(bus[5]),
    .hsync_in(bus[4]), .vsync_in(bus[3]), .general_control_in(bus[2:0]),
    .cap_valid_reg(cv), .first_pixel_reg(f), .second_pixel_reg(s),
    .second_valid_reg(sv), .active_video_reg(av), .hsync_reg(hs),
    .vsync_reg(vs), .control_reg(ct), .out_enable_reg(oe), .powered_reg(pw));
  always @(posedge clk)
    if (took)
      q.push_back({ps, bus[53:30], ps ? bus[29:6] : 24'h0, bus[5:0]});
  always @(negedge clk)
    if (cv === 1'b1)
    begin
      if (q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
        `CHK({sv, f, s, av, hs, vs, ct}, q.pop_front())
    end
  always @(posedge clk)
    if (++cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int m = 0; m < 4; m++)
    begin
      @(negedge clk) pdn = 0;
      repeat (10) @(negedge clk);
      `CHK({oe, pw, f, s, sv, cv, av, hs, vs, ct}, 58'h0)
      {es, ps} = 2'(m);
      @(negedge clk) pdn = 1;
      repeat (10) @(posedge clk);
      go = 1;
      repeat (120) @(posedge clk);
      while (pclk) @(posedge clk);
      go = 0;
      repeat (10) @(negedge clk);
      `CHK(q.size(), 0)
    end
    tally_and_finish;
  end
endmodule // pixel_input_capture_config_tb
`default_nettype wire
